/* File: common/sine_seq_pkg.sv */
package sine_seq_pkg;

    // System clock rate and period
    localparam int unsigned CLK_HZ    = 10_000_000;
    localparam int unsigned CLK_NS    = 100;

    // Register bus geometry
    localparam int ADDR_W             = 10;
    localparam int DATA_W             = 32;
    localparam logic [9:0] OFF_CTRL   = 10'h000;
    localparam logic [9:0] OFF_DIV    = 10'h004;
    localparam logic [9:0] OFF_HALF   = 10'h008;
    localparam logic [9:0] OFF_STAT   = 10'h00c;
    localparam logic [9:0] OFF_RAM    = 10'h200;
    localparam logic [9:0] OFF_RAM_LAST = 10'h2fc;
    localparam int RAM_IDX_LSB        = 2;
    localparam int RAM_IDX_W          = 6;
    localparam int RAM_BYTES          = 64;

    // Pattern region as the CPU sees it
    localparam logic [7:0] PATTERN_BASE = 8'h80;

    // Field positions and widths
    localparam int RUN_BIT            = 7;
    localparam int BIAS_BIT           = 4;
    localparam int DIV_W              = 6;
    localparam int HALF_W             = 5;
    localparam int SAMPLE_W           = 9;
    localparam int DAC_W              = 10;
    localparam int STAT_PHASE_BIT     = 8;
    localparam logic [9:0] DAC_MID    = 10'h200;

    // Reset values of the software registers
    localparam logic [5:0] DIV_RESET  = 6'h00;
    localparam logic [4:0] HALF_RESET = 5'h00;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Register selection after address decode
    typedef enum logic [2:0] {
        REG_CTRL = 3'b000,
        REG_DIV  = 3'b001,
        REG_HALF = 3'b010,
        REG_STAT = 3'b011,
        REG_RAM  = 3'b100,
        REG_NONE = 3'b101
    } reg_sel_t;

    // Sample word towards the DAC with its update pulse
    typedef struct packed {
        logic [9:0] code;
        logic       update;
    } wave_out_t;

    // Shared decoder for the read and write paths
    function automatic reg_sel_t reg_decode(input logic [9:0] addr);
        reg_sel_t sel;
        sel = REG_NONE;
        if (addr == OFF_CTRL) sel = REG_CTRL;
        else if (addr == OFF_DIV) sel = REG_DIV;
        else if (addr == OFF_HALF) sel = REG_HALF;
        else if (addr == OFF_STAT) sel = REG_STAT;
        else if (addr >= OFF_RAM && addr <= OFF_RAM_LAST && addr[1:0] == 2'h0) sel = REG_RAM;
        return sel;
    endfunction

endpackage

/* File: rtl/step_divider.sv */
`timescale 1ns/100ps
module step_divider
    import sine_seq_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Control
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] div_field,
    // One pulse every N clocks
    output logic                  step
);

    // Whole state of the divider
    typedef struct packed {
        logic [DIV_W-1:0] count;  // Clocks since last step
        logic             step;   // Registered step pulse
    } div_state_t;

    div_state_t s;       // Current state
    div_state_t next_s;  // Next state

    // Count to div_field, then pulse and restart
    always_comb begin
        next_s = s;
        next_s.step = 1'b0;
        if (!s.step && !run) begin
            next_s.count = '0;
        end else if (!run) begin
            next_s.count = '0;
        end else if (s.count == div_field) begin
            next_s.count = '0;
            next_s.step = 1'b1;
        end else begin
            next_s.count = s.count + 1'b1;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign step = s.step;

endmodule

/* File: rtl/wave_shaper.sv */
`timescale 1ns/100ps
module wave_shaper
    import sine_seq_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Sample in
    input  wire logic                run,
    input  wire logic                load,
    input  wire logic                phase,
    input  wire logic [SAMPLE_W-1:0] sample,
    // DAC word out
    output wave_out_t                wave
);

    wave_out_t s;       // Current output word
    wave_out_t next_s;  // Next output word

    // Offset the sample above or below midscale
    always_comb begin
        next_s = s;
        next_s.update = 1'b0;
        if (!run) begin
            // Park at midscale while powered down
            next_s.code = DAC_MID;
        end else if (load) begin
            next_s.update = 1'b1;
            if (phase) begin
                next_s.code = DAC_MID - {1'b0, sample};
            end else begin
                next_s.code = DAC_MID + {1'b0, sample};
            end
        end
    end

    // Output register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{code: DAC_MID, update: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign wave = s;

endmodule

/* File: rtl/sine_pattern_sequencer.sv */
// Summary of operation
// - Sine period is clock divided by M.
// - Sample index steps once every N clocks.
// - Half count is half full, at most 32.
// - Covers low to high output frequency range.
// - Example settings at 9.6 MHz clock given.
// - Half wave pattern stored in pattern RAM.
// - Low byte even address, ninth bit odd.
// - CPU locked out of RAM while running.
// - Samples fetched from RAM, sent to DAC.
// - Full sine built from half pattern.
// - Run bit 7 starts; zero powers down.
// - Bias bit 4 enables midscale bias.
// - Divider ratio is field plus one.
// - Half count is field plus one.
// - Unimplemented control bits read as zero.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module sine_pattern_sequencer
    import sine_seq_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Analog side
    output wave_out_t              wave_output_pin,
    output logic                   dac_power_on,
    output logic                   bias_on
);

    // Whole state of the sequencer and its bus slave
    // RAM kept as flops: small, and shared by two users
    typedef struct packed {
        logic                        awready;    // Address slot free
        logic                        aw_full;    // Write address held
        logic [ADDR_W-1:0]           aw_addr;    // Held write address
        logic                        wready;     // Data slot free
        logic                        w_full;     // Write data held
        logic [7:0]                  w_data;     // Held lane 0 byte
        logic                        w_lane0;    // Lane 0 strobe
        logic                        bvalid;     // Write answer pending
        logic [1:0]                  bresp;      // Write answer code
        logic                        arready;    // Read slot free
        logic                        rvalid;     // Read answer pending
        logic [DATA_W-1:0]           rdata;      // Read answer data
        logic [1:0]                  rresp;      // Read answer code
        logic                        run;        // wave_run_enable
        logic                        bias;       // bias_divider_enable
        logic [DIV_W-1:0]            div_field;  // sine_clock_divider
        logic [HALF_W-1:0]           half_field; // half_wave_sample_count
        logic [HALF_W-1:0]           index;      // Sample index in half
        logic                        phase;      // 0 upper, 1 lower half
        logic [RAM_BYTES-1:0][7:0]   ram;        // Pattern bytes
    } seq_state_t;

    // State and its next copy
    seq_state_t s;       // Current state
    seq_state_t next_s;  // Next state

    // Helper nets, none stored
    logic                 step;       // Divider pulse, one per N clocks
    logic [SAMPLE_W-1:0]  sample;     // Sample at current index
    reg_sel_t             wr_sel;     // Decoded write target
    reg_sel_t             rd_sel;     // Decoded read target
    logic [RAM_IDX_W-1:0] wr_idx;     // RAM byte for the write
    logic [RAM_IDX_W-1:0] rd_idx;     // RAM byte for the read
    logic [7:0]           fetch_addr; // Byte address being fetched

    // Protection bits are ignored; every access is treated alike
    // Upper lanes and strobes unused too
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[DATA_W-1:8],
                           s_axi_wstrb[3:1]};

    // N from 1 to 64
    // Own module, so its count stays apart
    step_divider step_divider_inst (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (s.run),
        .div_field (s.div_field),
        .step      (step)
    );

    // 9-bit entries, 32 deep
    // Combinational: ready on the step edge
    // low byte even, ninth bit odd
    assign sample = {s.ram[{s.index, 1'b1}][0], s.ram[{s.index, 1'b0}]};

    // Byte address of the fetch in CPU terms
    // Shown in status for software
    assign fetch_addr = PATTERN_BASE + {2'b00, s.index, 1'b0};

    // full wave formed at the pin
    // Registered, so the DAC word moves on one edge
    wave_shaper wave_shaper_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (s.run),
        .load    (step),
        .phase   (s.phase),
        .sample  (sample),
        .wave    (wave_output_pin)
    );

    // Bus slave, register file and sample stepping
    // Write lands two edges after the later half;
    // bvalid rises with it. A read is answered
    // on the edge after it is taken.
    // One process, so the readies can come last
    always_comb begin
        // Defaults: hold state, no target
        next_s = s;
        wr_sel = REG_NONE;
        rd_sel = REG_NONE;
        // Byte indices into the RAM window
        wr_idx = s.aw_addr[RAM_IDX_LSB +: RAM_IDX_W];
        rd_idx = s_axi_araddr[RAM_IDX_LSB +: RAM_IDX_W];

        // Take write address when offered
        // Held until the data joins it
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end

        // Take write data when offered, in either order
        // Registers are one byte: lane 0 only
        if (s_axi_wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = s_axi_wdata[7:0];
            next_s.w_lane0 = s_axi_wstrb[0];
        end

        // Write answer accepted by the master
        // Frees the slots for the next edge
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Both halves held: perform the write
        // Waits while an answer is still pending
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            // Default answer; cases may refuse
            wr_sel = reg_decode(s.aw_addr);
            unique case (wr_sel)
                REG_CTRL: begin
                    // Other bits have no storage
                    // run bit in top position
                    if (s.w_lane0) begin
                        next_s.run = s.w_data[RUN_BIT];
                        next_s.bias = s.w_data[BIAS_BIT];
                    end
                end

                REG_DIV: begin
                    // Only the low six bits are kept
                    // Below the live count: waits for wrap
                    if (s.w_lane0) begin
                        next_s.div_field = s.w_data[DIV_W-1:0];
                    end
                end

                REG_HALF: begin
                    // Below the live index: waits for wrap
                    // five bits cap the half at 32
                    if (s.w_lane0) begin
                        next_s.half_field = s.w_data[HALF_W-1:0];
                    end
                end

                REG_STAT: begin
                    // Status has no storage
                    // Read-only; write quietly dropped
                    next_s.bresp = RESP_OKAY;
                end

                REG_RAM: begin
                    // Byte from the held address
                    // writes refused while running
                    if (s.run) begin
                        next_s.bresp = RESP_SLVERR;
                    end else if (s.w_lane0) begin
                        next_s.ram[wr_idx] = s.w_data;
                    end
                end

                REG_NONE: begin
                    // Unmapped or misaligned
                    // Nothing decodes here
                    next_s.bresp = RESP_DECERR;
                end
            endcase
        end

        // Read answer accepted by the master
        // Frees the read slot for the next edge
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // Take a read and answer on the next edge
        // Decoded from the live bus address
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = '0;
            // From zero, so gaps read zero
            rd_sel = reg_decode(s_axi_araddr);
            unique case (rd_sel)
                REG_CTRL: begin
                    // Only run and bias exist
                    // unused bits read zero
                    next_s.rdata[RUN_BIT] = s.run;
                    next_s.rdata[BIAS_BIT] = s.bias;
                end

                REG_DIV: begin
                    // Field only; upper bits zero
                    next_s.rdata[DIV_W-1:0] = s.div_field;
                end

                REG_HALF: begin
                    // Field only; upper bits zero
                    next_s.rdata[HALF_W-1:0] = s.half_field;
                end

                REG_STAT: begin
                    // Live fetch address and half-wave phase
                    // Index doubles to a byte address
                    next_s.rdata[7:0] = fetch_addr;
                    next_s.rdata[STAT_PHASE_BIT] = s.phase;
                end

                REG_RAM: begin
                    // Refused read answers zero data
                    // reads refused while running
                    if (s.run) begin
                        next_s.rresp = RESP_SLVERR;
                    end else begin
                        next_s.rdata[7:0] = s.ram[rd_idx];
                    end
                end

                REG_NONE: begin
                    // Unmapped or misaligned
                    next_s.rresp = RESP_DECERR;
                end
            endcase
        end

        // Sample stepping through the half pattern
        // Shaper loads the old index on this step
        if (!s.run) begin
            // Divider restarts from run by itself
            // stopped sequencer returns to start
            next_s.index = '0;
            next_s.phase = 1'b0;
        end else if (step) begin
            // One index per divider pulse
            // wrap at half count, flip phase
            // half count is field plus one
            // 2 x half x N clocks per period
            if (s.index == s.half_field) begin
                next_s.index = '0;
                next_s.phase = ~s.phase;
            end else begin
                // Next sample of this half
                next_s.index = s.index + 1'b1;
            end
        end

        // Ready flags follow the slots; one of each in flight
        // From next values: a slot frees as its answer goes
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // State register; readies held low during reset
    // Pattern clears too; software reloads it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.div_field <= DIV_RESET;
            s.half_field <= HALF_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Bus outputs straight from the state
    // No logic between flop and pin
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // Amplifier and DAC share one enable
    // DAC and buffer amp powered only while running
    assign dac_power_on = s.run;
    // Bias runs even while stopped
    // bias follows its own bit
    assign bias_on = s.bias;

endmodule

/* File: tb/sine_seq_checker_assertions.sv */
`timescale 1ns/100ps
module sine_seq_checker
    import sine_seq_pkg::*;
(
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Bus handshakes
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Converter side
    input wire wave_out_t         wave_output_pin,
    input wire logic              dac_power_on
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stop_mid: assert property (
        (!dac_power_on) [*3] |-> wave_output_pin.code == DAC_MID && !wave_output_pin.update)
        else $error("code not parked while stopped");
    a_update_run: assert property (
        wave_output_pin.update |-> $past(dac_power_on))
        else $error("update while stopped");
    a_code_holds: assert property (
        dac_power_on && $past(dac_power_on) && !wave_output_pin.update |-> $stable(wave_output_pin.code))
        else $error("code moved without update");
    a_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_one_read: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_one_write: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answer pending");
endmodule

bind sine_pattern_sequencer sine_seq_checker sine_seq_checker_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wave_output_pin, .dac_power_on);

/* File: tb/dac_model.sv */
`timescale 1ns/100ps
module dac_model
    import sine_seq_pkg::*;
(
    // Clock
    input  wire logic      aclk,
    // Converter side
    input  wire wave_out_t wave,
    input  wire logic      power_on,
    // Observations
    output logic [9:0]     held,
    output logic [7:0]     bad
);
    logic was_on; // Power one cycle ago

    // Parked at midscale until the first sample
    initial begin
        held = DAC_MID;
        bad = 8'h00;
        was_on = 1'b0;
    end

    always @(posedge aclk) begin
        was_on <= power_on;
        if (wave.update && !power_on && !was_on) bad <= bad + 8'h01;
        if (wave.update) held <= wave.code;
    end
endmodule

/* File: tb/sine_pattern_sequencer_tb.sv */
`timescale 1ns/100ps
module sine_pattern_sequencer_tb;
    import sine_seq_pkg::*;
    // Bus, pins and bookkeeping
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d, cyc, first, prev;
    logic [3:0]        s_axi_wstrb;
    logic [2:0]        s_axi_awprot, s_axi_arprot;
    logic [1:0]        s_axi_bresp, s_axi_rresp, r;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, dac_power_on, bias_on;
    wave_out_t         wave_output_pin;
    logic [9:0]        held, e;
    logic [7:0]        bad;
    int                miscompares, compares;
    // Row: address, write data, read-back, both responses
    typedef struct packed {
        logic [9:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0]  wr_r;
        logic [1:0]  rd_r;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{OFF_CTRL, 32'h6f, 32'h00, RESP_OKAY, RESP_OKAY},
        '{OFF_CTRL, 32'h7f, 32'h10, RESP_OKAY, RESP_OKAY},
        '{OFF_DIV, 32'hff, 32'h3f, RESP_OKAY, RESP_OKAY},
        '{OFF_HALF, 32'hff, 32'h1f, RESP_OKAY, RESP_OKAY},
        '{OFF_STAT, 32'h1ff, 32'h80, RESP_OKAY, RESP_OKAY},
        '{OFF_RAM, 32'ha5, 32'ha5, RESP_OKAY, RESP_OKAY},
        '{10'h010, 32'h01, 32'h00, RESP_DECERR, RESP_DECERR},
        '{10'h206, 32'h01, 32'h00, RESP_DECERR, RESP_DECERR}};
    localparam logic [8:0] SMP [4] = '{9'h101, 9'h0ff, 9'h1a0, 9'h0c3};
    localparam logic [9:0] RST_A [4] = '{OFF_CTRL, OFF_DIV, OFF_HALF, OFF_RAM};

    sine_pattern_sequencer sine_pattern_sequencer_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .wave_output_pin, .dac_power_on, .bias_on);
    dac_model dac_model_inst (.aclk, .wave(wave_output_pin), .power_on(dac_power_on),
        .held, .bad);

    // Free-running clock
    initial begin
        aclk = 1'b0;
        forever #(CLK_NS / 2) aclk = ~aclk;
    end
    // Cycle stamp for spacing checks
    always @(posedge aclk) cyc <= cyc + 32'h1;

    // Count and report one comparison
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hold reset low for twelve edges
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // Write: offer both halves, answer ready only once bvalid shows
    task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read: the late rready exercises the hold of rdata
    task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        give_verdict();
    end

    initial begin
        // Quiet bus at time zero
        aresetn = 1'b0;
        cyc = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awprot, s_axi_arprot} = 6'h00;
        s_axi_wstrb = 4'hf;
        do_reset();
        // Register rows
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d, r);
            chk(32'(r), 32'(ROWS[i].wr_r));
            rd(ROWS[i].a, d, r);
            chk(d, ROWS[i].q);
            chk(32'(r), 32'(ROWS[i].rd_r));
        end
        chk(32'(bias_on), 32'h1);
        chk(32'(dac_power_on), 32'h0);
        // Lane 0 strobe low: answered, register kept
        s_axi_wstrb <= 4'he;
        wr(OFF_DIV, 32'h15, r);
        s_axi_wstrb <= 4'hf;
        chk(32'(r), 32'(RESP_OKAY));
        rd(OFF_DIV, d, r);
        chk(d, 32'h3f);
        // N of 3, DN of 8, M of 24
        for (int i = 0; i < 4; i++) begin
            wr(OFF_RAM + 10'(i * 8), 32'(SMP[i][7:0]), r);
            wr(OFF_RAM + 10'(i * 8 + 4), 32'(SMP[i][8]), r);
        end
        wr(OFF_DIV, 32'h2, r);
        wr(OFF_HALF, 32'h3, r);
        wr(OFF_CTRL, 32'h90, r);
        // Nine updates: both halves and the wrap
        for (int k = 0; k < 9; k++) begin
            do @(posedge aclk); while (!wave_output_pin.update);
            e = DAC_MID + 10'(SMP[k % 4]);
            if ((k / 4) % 2 == 1) e = DAC_MID - 10'(SMP[k % 4]);
            chk(32'(wave_output_pin.code), 32'(e));
            if (k > 0) chk(cyc - prev, 32'h3);
            if (k == 0) first = cyc;
            prev = cyc;
        end
        chk(cyc - first, 32'h18);
        @(posedge aclk);
        chk(32'(held), 32'h301);
        // Pattern region locked while running
        rd(OFF_RAM, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(OFF_RAM, 32'h33, r);
        chk(32'(r), 32'(RESP_SLVERR));
        // Stop: parked, index home, region free, write was dropped
        wr(OFF_CTRL, 32'h0, r);
        repeat (3) @(posedge aclk);
        chk(32'(wave_output_pin.code), 32'(DAC_MID));
        rd(OFF_STAT, d, r);
        chk(d, 32'h80);
        rd(OFF_RAM, d, r);
        chk(d, 32'h01);
        chk(32'(bad), 32'h0);
        chk(32'(bias_on), 32'h0);
        // Reset in mid-run clears everything
        wr(OFF_CTRL, 32'h90, r);
        repeat (7) @(posedge aclk);
        do_reset();
        chk(32'(wave_output_pin.code), 32'(DAC_MID));
        foreach (RST_A[i]) begin
            rd(RST_A[i], d, r);
            chk(d, 32'h0);
        end
        give_verdict();
    end
endmodule
